// ### verilog/usrac_pkg.sv
package usrac_pkg;
   // Standard request codes
   localparam logic [7:0] REQ_GET_STATUS  = 8'h00;
   localparam logic [7:0] REQ_CLR_FEATURE = 8'h01;
   localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
   localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
   localparam logic [7:0] REQ_SET_CONFIG  = 8'h09;
   localparam logic [7:0] REQ_SET_IFACE   = 8'h0b;
   // Request type codes per recipient
   localparam logic [7:0] RT_GET_DEV = 8'h80;
   localparam logic [7:0] RT_GET_IF  = 8'h81;
   localparam logic [7:0] RT_GET_EP  = 8'h82;
   localparam logic [7:0] RT_SET_DEV = 8'h00;
   localparam logic [7:0] RT_SET_IF  = 8'h01;
   localparam logic [7:0] RT_SET_EP  = 8'h02;
   localparam int         RT_DIR_BIT = 7;
   localparam logic [1:0] RT_TYPE_STD = 2'h0;
   // Feature selectors
   localparam logic [15:0] FS_EP_HALT = 16'h0000;
   localparam logic [15:0] FS_RWAKE   = 16'h0001;
   // Status word fields
   localparam int DS_SELF_PWR_BIT = 0;
   localparam int DS_RWAKE_BIT    = 1;
   localparam int EP_HALT_BIT     = 0;
   localparam logic [15:0] GET_STATUS_LEN = 16'h0002;
   // Device resources
   localparam int         ADDR_W       = 7;
   localparam int         NUM_EP       = 4;
   localparam int         EP_IDX_W     = 2;
   localparam logic [7:0] NUM_IF       = 8'h01;
   localparam logic [7:0] CFG_VALUE    = 8'h01;
   // Host register map, 16-bit data
   localparam logic [3:0] HR_SETUP0 = 4'h0;
   localparam logic [3:0] HR_VALUE  = 4'h1;
   localparam logic [3:0] HR_INDEX  = 4'h2;
   localparam logic [3:0] HR_LENGTH = 4'h3;
   localparam logic [3:0] HR_TARGET = 4'h4;
   localparam logic [3:0] HR_CTRL   = 4'h5;
   localparam logic [3:0] HR_STATUS = 4'h6;
   localparam logic [3:0] HR_DATA   = 4'h7;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_BRST_BIT  = 1;
   // Response timeout of the host
   localparam int RSP_TIMEOUT_NS = 512;
   localparam int CLK_PERIOD_NS  = 8;
   localparam int TMO_W          = 7;
   localparam logic [TMO_W-1:0] TMO_CYC = TMO_W'(RSP_TIMEOUT_NS / CLK_PERIOD_NS - 1);

   typedef enum logic [1:0] {
      DS_DEFAULT,
      DS_ADDRESS,
      DS_CONFIGURED
   } usrac_dev_st_t;

   typedef enum logic [2:0] {
      HS_IDLE,
      HS_SETUP,
      HS_SETUP_W,
      HS_DATA,
      HS_DATA_W,
      HS_STAT,
      HS_STAT_W
   } usrac_host_st_t;
endpackage

// ### verilog/usrac_link_if.sv
`timescale 1ns/1ps
interface usrac_link_if;
   logic                          bus_rst;
   logic [usrac_pkg::ADDR_W-1:0] tok_addr;
   logic                          setup_vld;
   logic [7:0]                    bm_type;
   logic [7:0]                    b_req;
   logic [15:0]                   w_value;
   logic [15:0]                   w_index;
   logic [15:0]                   w_length;
   logic                          data_req;
   logic                          stat_req;
   logic                          stat_in;
   logic                          rsp_vld;
   logic                          rsp_stall;
   logic [15:0]                   rsp_data;

   modport dev (
      input  bus_rst, tok_addr, setup_vld, bm_type, b_req, w_value, w_index, w_length,
      input  data_req, stat_req, stat_in,
      output rsp_vld, rsp_stall, rsp_data
   );
   modport host (
      output bus_rst, tok_addr, setup_vld, bm_type, b_req, w_value, w_index, w_length,
      output data_req, stat_req, stat_in,
      input  rsp_vld, rsp_stall, rsp_data
   );
endinterface

// ### verilog/usrac_dev.sv
`timescale 1ns/1ps
module usrac_dev (
   input  wire logic                            clock_i,
   input  wire logic                            arst_n_i,
   usrac_link_if.dev                            lnk,
   input  wire logic                            self_pwr_i,
   input  wire logic [usrac_pkg::NUM_EP-1:0]    hw_halt_i,
   output logic      [usrac_pkg::NUM_EP-1:0]    halt_o,
   output logic      [usrac_pkg::NUM_EP-1:0]    toggle_clr_o,
   output usrac_pkg::usrac_dev_st_t             dev_state_o,
   output logic      [usrac_pkg::ADDR_W-1:0]    dev_addr_o,
   output logic      [7:0]                      cfg_o,
   output logic                                 rwake_en_o
);
   typedef struct packed {
      usrac_pkg::usrac_dev_st_t          st;
      logic [usrac_pkg::ADDR_W-1:0]      addr;
      logic [usrac_pkg::ADDR_W-1:0]      pend_addr;
      logic                              setaddr;
      logic                              err;
      logic [15:0]                       word;
      logic [7:0]                        cfg;
      logic                              rwake;
      logic [usrac_pkg::NUM_EP-1:0]      halt;
      logic [usrac_pkg::NUM_EP-1:0]      tog_clr;
      logic                              rsp_vld;
      logic                              rsp_stall;
      logic [15:0]                       rsp_data;
   } usrac_dev_regs_t;

   usrac_dev_regs_t                      q;
   usrac_dev_regs_t                      d;
   logic                                 hit;
   logic                                 std_req;
   logic                                 fs_req;
   logic                                 ep_ok;
   logic                                 if_ok;
   logic [usrac_pkg::EP_IDX_W-1:0]       ep_sel;
   logic                                 is_set;

   // Request decode, shared by all recipients
   assign hit     = (lnk.tok_addr == q.addr);
   assign std_req = (lnk.bm_type[6:5] == usrac_pkg::RT_TYPE_STD);
   assign is_set  = (lnk.b_req == usrac_pkg::REQ_SET_FEATURE);
   assign fs_req  = is_set || (lnk.b_req == usrac_pkg::REQ_CLR_FEATURE);
   assign ep_sel  = lnk.w_index[usrac_pkg::EP_IDX_W-1:0];
   // Endpoints above zero only exist once configured
   assign ep_ok   = (lnk.w_index[15:usrac_pkg::EP_IDX_W] == '0)
                    && ((ep_sel == '0) || (q.st == usrac_pkg::DS_CONFIGURED));
   // Interfaces exist only in the configured state
   assign if_ok   = (q.st == usrac_pkg::DS_CONFIGURED) && (lnk.w_index[15:8] == 8'h00)
                    && (lnk.w_index[7:0] < usrac_pkg::NUM_IF);

   // Next state of the whole device
   always_comb begin
      d         = q;
      d.tog_clr = '0;
      d.rsp_vld = 1'b0;
      d.rsp_stall = 1'b0;
      // Setup stage: decode and carry out the request right away, except the address change
      if (lnk.setup_vld && hit) begin
         d.rsp_vld = 1'b1;
         d.err     = 1'b0;
         d.setaddr = 1'b0;
         d.word    = '0;
         if (!std_req) begin
            d.err = 1'b1;
         end else if (q.halt[0] && !fs_req && (lnk.b_req != usrac_pkg::REQ_GET_STATUS)) begin
            d.err = 1'b1;
         end else begin
            case (lnk.b_req)
               usrac_pkg::REQ_GET_STATUS: begin
                  case (lnk.bm_type)
                     usrac_pkg::RT_GET_DEV: begin
                        d.word[usrac_pkg::DS_SELF_PWR_BIT] = self_pwr_i;
                        d.word[usrac_pkg::DS_RWAKE_BIT]    = q.rwake;
                     end
                     usrac_pkg::RT_GET_IF: begin
                        d.err = !if_ok;
                     end
                     usrac_pkg::RT_GET_EP: begin
                        d.err = !ep_ok;
                        d.word[usrac_pkg::EP_HALT_BIT] = q.halt[ep_sel];
                     end
                     default: d.err = 1'b1;
                  endcase
               end
               usrac_pkg::REQ_SET_FEATURE,
               usrac_pkg::REQ_CLR_FEATURE: begin
                  // The power bit is never a settable feature
                  if (lnk.bm_type == usrac_pkg::RT_SET_DEV
                      && lnk.w_value == usrac_pkg::FS_RWAKE) begin
                     d.rwake = is_set;
                  end else if (lnk.bm_type == usrac_pkg::RT_SET_EP
                               && lnk.w_value == usrac_pkg::FS_EP_HALT && ep_ok) begin
                     d.halt[ep_sel] = is_set;
                     d.tog_clr[ep_sel] = !is_set;
                  end else begin
                     d.err = 1'b1;
                  end
               end
               usrac_pkg::REQ_SET_ADDRESS: begin
                  // Held until the status stage succeeds
                  d.pend_addr = lnk.w_value[usrac_pkg::ADDR_W-1:0];
                  d.setaddr   = (lnk.bm_type == usrac_pkg::RT_SET_DEV);
                  d.err       = (lnk.bm_type != usrac_pkg::RT_SET_DEV);
               end
               usrac_pkg::REQ_SET_CONFIG: begin
                  // Default state behaviour is open; refuse it
                  if (q.st == usrac_pkg::DS_DEFAULT || lnk.bm_type != usrac_pkg::RT_SET_DEV) begin
                     d.err = 1'b1;
                  end else if (lnk.w_value[7:0] == 8'h00) begin
                     d.st  = usrac_pkg::DS_ADDRESS;
                     d.cfg = 8'h00;
                     d.halt = '0;
                     d.tog_clr = '1;
                  end else if (lnk.w_value[7:0] == usrac_pkg::CFG_VALUE) begin
                     d.st  = usrac_pkg::DS_CONFIGURED;
                     d.cfg = lnk.w_value[7:0];
                     d.halt = '0;
                     d.tog_clr = '1;
                  end else begin
                     d.err = 1'b1;
                  end
               end
               usrac_pkg::REQ_SET_IFACE: begin
                  // Only the default setting of each interface exists
                  if (lnk.bm_type == usrac_pkg::RT_SET_IF && if_ok && lnk.w_value == 16'h0000) begin
                     d.halt = '0;
                     d.tog_clr = '1;
                  end else begin
                     d.err = 1'b1;
                  end
               end
               default: d.err = 1'b1;
            endcase
         end
      end
      // Data stage towards the host
      if (lnk.data_req && hit) begin
         d.rsp_vld   = 1'b1;
         d.rsp_stall = q.err;
         d.rsp_data  = q.err ? 16'h0000 : q.word;
      end
      // Status stage; apart from bus reset, the address switches only here
      if (lnk.stat_req && hit) begin
         d.rsp_vld   = 1'b1;
         d.rsp_stall = q.err;
         if (!q.err && q.setaddr) begin
            d.addr    = q.pend_addr;
            d.setaddr = 1'b0;
            d.st      = (q.pend_addr != '0) ? usrac_pkg::DS_ADDRESS : usrac_pkg::DS_DEFAULT;
            d.cfg     = 8'h00;
         end
      end
      // Hardware halt causes win over a clear in the same cycle
      d.halt = d.halt | hw_halt_i;
      // Bus reset returns everything to Default
      if (lnk.bus_rst) begin
         d = '0;
      end
   end

   // State register
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign lnk.rsp_vld   = q.rsp_vld;
   assign lnk.rsp_stall = q.rsp_stall;
   assign lnk.rsp_data  = q.rsp_data;
   assign halt_o        = q.halt;
   assign toggle_clr_o  = q.tog_clr;
   assign dev_state_o   = q.st;
   assign dev_addr_o    = q.addr;
   assign cfg_o         = q.cfg;
   assign rwake_en_o    = q.rwake;
endmodule // usrac_dev

// ### verilog/usrac_host.sv
`timescale 1ns/1ps
module usrac_host (
   input  wire logic          clock_i,
   input  wire logic          arst_n_i,
   usrac_link_if.host         lnk,
   input  wire logic [3:0]    addr_i,
   input  wire logic [15:0]   wdata_i,
   input  wire logic          we_i,
   input  wire logic          re_i,
   output logic      [15:0]   rdata_o
);
   typedef struct packed {
      usrac_pkg::usrac_host_st_t       st;
      logic [7:0]                      bm;
      logic [7:0]                      breq;
      logic [15:0]                     val;
      logic [15:0]                     idx;
      logic [15:0]                     len;
      logic [usrac_pkg::ADDR_W-1:0]    tgt;
      logic                            brst;
      logic                            done;
      logic                            stall;
      logic                            tmo;
      logic [15:0]                     word;
      logic [usrac_pkg::TMO_W-1:0]     tmr;
      logic [15:0]                     rd;
   } usrac_host_regs_t;

   usrac_host_regs_t q;
   usrac_host_regs_t d;
   logic             busy;
   logic             has_in;
   logic             wait_st;

   assign busy    = (q.st != usrac_pkg::HS_IDLE);
   assign has_in  = q.bm[usrac_pkg::RT_DIR_BIT] && (q.len != 16'h0000);
   assign wait_st = (q.st == usrac_pkg::HS_SETUP_W) || (q.st == usrac_pkg::HS_DATA_W)
                    || (q.st == usrac_pkg::HS_STAT_W);

   // Register port, sequencer and response wait
   always_comb begin
      d      = q;
      d.brst = 1'b0;
      d.rd   = 16'h0000;
      if (re_i) begin
         case (addr_i)
            usrac_pkg::HR_SETUP0: d.rd = {q.breq, q.bm};
            usrac_pkg::HR_VALUE:  d.rd = q.val;
            usrac_pkg::HR_INDEX:  d.rd = q.idx;
            usrac_pkg::HR_LENGTH: d.rd = q.len;
            usrac_pkg::HR_TARGET: d.rd = {9'h000, q.tgt};
            usrac_pkg::HR_STATUS: d.rd = {12'h000, q.tmo, q.stall, q.done, busy};
            usrac_pkg::HR_DATA:   d.rd = q.word;
            default:              d.rd = 16'h0000;
         endcase
      end
      // Field writes are ignored while a transfer runs
      if (we_i && !busy) begin
         case (addr_i)
            usrac_pkg::HR_SETUP0: begin
               d.bm   = wdata_i[7:0];
               d.breq = wdata_i[15:8];
            end
            usrac_pkg::HR_VALUE:  d.val = wdata_i;
            usrac_pkg::HR_INDEX:  d.idx = wdata_i;
            usrac_pkg::HR_LENGTH: d.len = wdata_i;
            usrac_pkg::HR_TARGET: d.tgt = wdata_i[usrac_pkg::ADDR_W-1:0];
            usrac_pkg::HR_CTRL: begin
               d.brst = wdata_i[usrac_pkg::CTRL_BRST_BIT];
               if (wdata_i[usrac_pkg::CTRL_START_BIT] && !wdata_i[usrac_pkg::CTRL_BRST_BIT]) begin
                  d.st    = usrac_pkg::HS_SETUP;
                  d.done  = 1'b0;
                  d.stall = 1'b0;
                  d.tmo   = 1'b0;
                  // Fields forced to their only legal values
                  case (q.breq)
                     usrac_pkg::REQ_GET_STATUS: begin
                        d.val = 16'h0000;
                        d.len = usrac_pkg::GET_STATUS_LEN;
                     end
                     usrac_pkg::REQ_SET_ADDRESS: begin
                        d.bm  = usrac_pkg::RT_SET_DEV;
                        d.val = {9'h000, q.val[usrac_pkg::ADDR_W-1:0]};
                        d.idx = 16'h0000;
                        d.len = 16'h0000;
                     end
                     usrac_pkg::REQ_SET_CONFIG: begin
                        d.val = {8'h00, q.val[7:0]};
                        d.idx = 16'h0000;
                        d.len = 16'h0000;
                     end
                     default: d.len = q.bm[usrac_pkg::RT_DIR_BIT] ? q.len : 16'h0000;
                  endcase
               end
            end
            default: ;
         endcase
      end
      d.tmr = wait_st ? q.tmr + 1'b1 : '0;
      case (q.st)
         usrac_pkg::HS_IDLE:  ;
         usrac_pkg::HS_SETUP: d.st = usrac_pkg::HS_SETUP_W;
         usrac_pkg::HS_DATA:  d.st = usrac_pkg::HS_DATA_W;
         usrac_pkg::HS_STAT:  d.st = usrac_pkg::HS_STAT_W;
         usrac_pkg::HS_SETUP_W,
         usrac_pkg::HS_DATA_W,
         usrac_pkg::HS_STAT_W: begin
            if (lnk.rsp_vld) begin
               if (lnk.rsp_stall) begin
                  d.st    = usrac_pkg::HS_IDLE;
                  d.stall = 1'b1;
                  d.done  = 1'b1;
               end else if (q.st == usrac_pkg::HS_SETUP_W) begin
                  d.st = has_in ? usrac_pkg::HS_DATA : usrac_pkg::HS_STAT;
               end else if (q.st == usrac_pkg::HS_DATA_W) begin
                  d.word = lnk.rsp_data;
                  d.st   = usrac_pkg::HS_STAT;
               end else begin
                  d.st   = usrac_pkg::HS_IDLE;
                  d.done = 1'b1;
               end
            end else if (q.tmr == usrac_pkg::TMO_CYC) begin
               // A silent device must not hang the sequencer
               d.st   = usrac_pkg::HS_IDLE;
               d.tmo  = 1'b1;
               d.done = 1'b1;
            end
         end
         default: d.st = usrac_pkg::HS_IDLE;
      endcase
      if (q.brst) begin
         d.st = usrac_pkg::HS_IDLE;
      end
   end

   // State register
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Link drive: stage strobes decoded from state, bus reset and fields from flops
   assign lnk.bus_rst   = q.brst;
   assign lnk.tok_addr  = q.tgt;
   assign lnk.setup_vld = (q.st == usrac_pkg::HS_SETUP);
   assign lnk.bm_type   = q.bm;
   assign lnk.b_req     = q.breq;
   assign lnk.w_value   = q.val;
   assign lnk.w_index   = q.idx;
   assign lnk.w_length  = q.len;
   assign lnk.data_req  = (q.st == usrac_pkg::HS_DATA);
   assign lnk.stat_req  = (q.st == usrac_pkg::HS_STAT);
   assign lnk.stat_in   = !has_in;
   assign rdata_o       = q.rd;
endmodule // usrac_host

// ### verif/usrac_properties.sv
`timescale 1ns/1ps
module usrac_properties (
   input wire logic        clock_i,
   input wire logic        arst_n_i,
   input wire logic        setup_vld_i,
   input wire logic [7:0]  bm_type_i,
   input wire logic [7:0]  b_req_i,
   input wire logic [15:0] w_value_i,
   input wire logic [15:0] w_index_i,
   input wire logic [15:0] w_length_i,
   input wire logic        data_req_i,
   input wire logic        stat_req_i,
   input wire logic        stat_in_i,
   input wire logic        rsp_vld_i,
   input wire logic        rsp_stall_i,
   input wire logic [15:0] rsp_data_i
);
   logic gs_q;
   logic gs_ok;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   // Marks the answer cycle of a status-query data stage
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gs_q <= 1'b0;
      end else begin
         gs_q <= data_req_i && b_req_i == usrac_pkg::REQ_GET_STATUS;
      end
   end
   assign gs_ok = rsp_vld_i && !rsp_stall_i && gs_q;

   a_rsp_has_cause: assert property (rsp_vld_i |-> $past(setup_vld_i || data_req_i || stat_req_i))
      else $error("answer without request");
   a_setup_acked: assert property (rsp_vld_i && $past(setup_vld_i) |-> !rsp_stall_i)
      else $error("setup stage refused");
   a_dev_word: assert property (gs_ok && bm_type_i == usrac_pkg::RT_GET_DEV
      |-> rsp_data_i[15:2] == 14'h0000) else $error("device status spare bits set");
   a_if_word: assert property (gs_ok && bm_type_i == usrac_pkg::RT_GET_IF |-> rsp_data_i == 16'h0000)
      else $error("interface status not zero");
   a_ep_word: assert property (gs_ok && bm_type_i == usrac_pkg::RT_GET_EP
      |-> rsp_data_i[15:1] == 15'h0000) else $error("endpoint status spare bits set");
   a_bad_ep: assert property (rsp_vld_i && gs_q && bm_type_i == usrac_pkg::RT_GET_EP
      && w_index_i[15:2] != 14'h0000 |-> rsp_stall_i) else $error("missing endpoint answered");
   a_addr_no_data: assert property ((setup_vld_i && b_req_i == usrac_pkg::REQ_SET_ADDRESS
      && bm_type_i == usrac_pkg::RT_SET_DEV) ##1 rsp_vld_i |-> ##1 (stat_req_i && stat_in_i && !data_req_i))
      else $error("address request has data stage");
   a_status_opposite: assert property ((setup_vld_i && bm_type_i[7] && w_length_i != 16'h0000)
      ##1 rsp_vld_i ##1 data_req_i ##1 (rsp_vld_i && !rsp_stall_i) |-> ##1 (stat_req_i && !stat_in_i))
      else $error("status stage not opposite");
   a_query_fields: assert property (setup_vld_i && bm_type_i[7] && b_req_i == usrac_pkg::REQ_GET_STATUS
      |-> w_value_i == 16'h0000 && w_length_i == usrac_pkg::GET_STATUS_LEN) else $error("bad query fields");
   a_addr_fields: assert property (setup_vld_i && b_req_i == usrac_pkg::REQ_SET_ADDRESS
      |-> w_value_i[15:7] == 9'h000 && w_index_i == 16'h0000 && w_length_i == 16'h0000) else $error("bad address");
endmodule // usrac_properties

// ### verif/usrac_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value at %0t: got %h, expected %h", $time, (g), (e)); end end
module usrac_test;
   logic                     clock_i;
   logic                     arst_n_i;
   logic                     self_pwr;
   logic [3:0]               hw_halt;
   logic [3:0]               addr;
   logic [15:0]              wdata;
   logic                     we;
   logic                     re;
   logic [15:0]              rdata;
   logic [3:0]               halt;
   logic [3:0]               tclr;
   usrac_pkg::usrac_dev_st_t state;
   logic [6:0]               daddr;
   logic [7:0]               cfg;
   logic                     rwake;
   int                       tc;
   int                       err_count;
   int                       tests_run;

   usrac_link_if lnk ();
   usrac_host usrac_host_inst (.clock_i, .arst_n_i, .lnk(lnk), .addr_i(addr), .wdata_i(wdata), .we_i(we),
                               .re_i(re), .rdata_o(rdata));
   usrac_dev usrac_dev_inst (.clock_i, .arst_n_i, .lnk(lnk), .self_pwr_i(self_pwr), .hw_halt_i(hw_halt),
                             .halt_o(halt), .toggle_clr_o(tclr), .dev_state_o(state), .dev_addr_o(daddr),
                             .cfg_o(cfg), .rwake_en_o(rwake));
   usrac_properties usrac_properties_inst (.clock_i, .arst_n_i, .setup_vld_i(lnk.setup_vld),
      .bm_type_i(lnk.bm_type), .b_req_i(lnk.b_req), .w_value_i(lnk.w_value), .w_index_i(lnk.w_index),
      .w_length_i(lnk.w_length), .data_req_i(lnk.data_req), .stat_req_i(lnk.stat_req),
      .stat_in_i(lnk.stat_in), .rsp_vld_i(lnk.rsp_vld), .rsp_stall_i(lnk.rsp_stall), .rsp_data_i(lnk.rsp_data));

   // Toggle pulses are one cycle wide, so keep a running count
   always @(posedge clock_i) tc <= tc + $countones(tclr);

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clock_i);
      we <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock_i);
      addr <= a;
      re <= 1'b1;
      @(posedge clock_i);
      re <= 1'b0;
      #1 d = rdata;
   endtask

   // One transfer; e is the expected {timeout, stall} pair
   task automatic req(input logic [7:0] bm, rq, input logic [15:0] v, ix, input logic [1:0] e,
                      output logic [15:0] d);
      logic [15:0] s;
      wr(usrac_pkg::HR_SETUP0, {rq, bm});
      wr(usrac_pkg::HR_VALUE, v);
      wr(usrac_pkg::HR_INDEX, ix);
      wr(usrac_pkg::HR_CTRL, 16'h0001);
      repeat (60) begin
         rd(usrac_pkg::HR_STATUS, s);
         if (s[1:0] === 2'h2) break;
      end
      `CHK(s[3:1], {e, 1'b1})
      rd(usrac_pkg::HR_DATA, d);
   endtask

   task automatic gs(input logic [1:0] r, input logic [15:0] ix, input logic [1:0] e, input logic [15:0] x);
      logic [15:0] d;
      // A stray value field must be cleared by the host
      req({usrac_pkg::RT_GET_DEV[7:2], r}, usrac_pkg::REQ_GET_STATUS, 16'h00ff, ix, e, d);
      if (e == 2'h0) `CHK(d, x)
   endtask

   task automatic sr(input logic [1:0] r, input logic [7:0] rq, input logic [15:0] v, ix, input logic [1:0] e);
      logic [15:0] d;
      req({usrac_pkg::RT_SET_DEV[7:2], r}, rq, v, ix, e, d);
   endtask

   // Default state: power bit, then the address moves after status
   task automatic t_fresh();
      @(posedge clock_i);
      self_pwr <= 1'b1;
      gs(2'h0, 16'h0000, 2'h0, 16'h0001);
      @(posedge clock_i);
      self_pwr <= 1'b0;
      gs(2'h0, 16'h0000, 2'h0, 16'h0000);
      sr(2'h0, usrac_pkg::REQ_SET_ADDRESS, 16'h0000, 16'h0000, 2'h0);
      `CHK(state, usrac_pkg::DS_DEFAULT)
      sr(2'h0, usrac_pkg::REQ_SET_ADDRESS, 16'h0085, 16'h0003, 2'h0);
      `CHK({state, daddr}, {usrac_pkg::DS_ADDRESS, 7'h05})
      gs(2'h0, 16'h0000, 2'h2, 16'h0000);
      wr(usrac_pkg::HR_TARGET, 16'h0005);
   endtask

   // Address state: limited queries, wakeup, configuration
   task automatic t_address();
      gs(2'h1, 16'h0000, 2'h1, 16'h0000);
      gs(2'h2, 16'h0001, 2'h1, 16'h0000);
      gs(2'h2, 16'h0000, 2'h0, 16'h0000);
      @(posedge clock_i);
      self_pwr <= 1'b1;
      sr(2'h0, usrac_pkg::REQ_SET_FEATURE, usrac_pkg::FS_RWAKE, 16'h0000, 2'h0);
      sr(2'h0, usrac_pkg::REQ_CLR_FEATURE, usrac_pkg::FS_EP_HALT, 16'h0000, 2'h1);
      gs(2'h0, 16'h0000, 2'h0, 16'h0003);
      sr(2'h0, usrac_pkg::REQ_CLR_FEATURE, usrac_pkg::FS_RWAKE, 16'h0000, 2'h0);
      `CHK(rwake, 1'b0)
      sr(2'h0, usrac_pkg::REQ_SET_CONFIG, 16'h0002, 16'h0000, 2'h1);
      sr(2'h0, usrac_pkg::REQ_SET_CONFIG, 16'h0000, 16'h0000, 2'h0);
      `CHK({state, cfg}, {usrac_pkg::DS_ADDRESS, 8'h00})
      sr(2'h0, usrac_pkg::REQ_SET_CONFIG, 16'h0301, 16'h0000, 2'h0);
      `CHK({state, cfg}, {usrac_pkg::DS_CONFIGURED, usrac_pkg::CFG_VALUE})
   endtask

   // Configured: halts, toggles, control pipe halt, leave
   task automatic t_config();
      int t0;
      sr(2'h2, usrac_pkg::REQ_SET_FEATURE, usrac_pkg::FS_EP_HALT, 16'h0002, 2'h0);
      gs(2'h2, 16'h0002, 2'h0, 16'h0001);
      gs(2'h2, 16'h0004, 2'h1, 16'h0000);
      gs(2'h1, 16'h0000, 2'h0, 16'h0000);
      @(posedge clock_i);
      hw_halt <= 4'h2;
      gs(2'h2, 16'h0001, 2'h0, 16'h0001);
      @(posedge clock_i);
      hw_halt <= 4'h0;
      t0 = tc;
      sr(2'h2, usrac_pkg::REQ_CLR_FEATURE, usrac_pkg::FS_EP_HALT, 16'h0001, 2'h0);
      sr(2'h2, usrac_pkg::REQ_CLR_FEATURE, usrac_pkg::FS_EP_HALT, 16'h0003, 2'h0);
      `CHK({halt, tc - t0}, {4'h4, 32'd2})
      sr(2'h0, usrac_pkg::REQ_SET_CONFIG, 16'h0001, 16'h0000, 2'h0);
      `CHK({state, halt}, {usrac_pkg::DS_CONFIGURED, 4'h0})
      sr(2'h2, usrac_pkg::REQ_SET_FEATURE, usrac_pkg::FS_EP_HALT, 16'h0001, 2'h0);
      `CHK(halt, 4'h2)
      sr(2'h1, usrac_pkg::REQ_SET_IFACE, 16'h0000, 16'h0000, 2'h0);
      `CHK(halt, 4'h0)
      sr(2'h0, usrac_pkg::REQ_SET_CONFIG, 16'h0003, 16'h0000, 2'h1);
      `CHK({state, cfg}, {usrac_pkg::DS_CONFIGURED, usrac_pkg::CFG_VALUE})
      sr(2'h2, usrac_pkg::REQ_SET_FEATURE, usrac_pkg::FS_EP_HALT, 16'h0000, 2'h0);
      sr(2'h0, usrac_pkg::REQ_SET_CONFIG, 16'h0001, 16'h0000, 2'h1);
      gs(2'h2, 16'h0000, 2'h0, 16'h0001);
      sr(2'h2, usrac_pkg::REQ_CLR_FEATURE, usrac_pkg::FS_EP_HALT, 16'h0000, 2'h0);
      sr(2'h0, usrac_pkg::REQ_SET_CONFIG, 16'h0000, 16'h0000, 2'h0);
      `CHK({state, cfg}, {usrac_pkg::DS_ADDRESS, 8'h00})
   endtask

   // Back to Default, then a bus reset drops the wakeup enable
   task automatic t_leave();
      sr(2'h0, usrac_pkg::REQ_SET_FEATURE, usrac_pkg::FS_RWAKE, 16'h0000, 2'h0);
      sr(2'h0, usrac_pkg::REQ_SET_ADDRESS, 16'h0000, 16'h0000, 2'h0);
      `CHK(state, usrac_pkg::DS_DEFAULT)
      wr(usrac_pkg::HR_TARGET, 16'h0000);
      wr(usrac_pkg::HR_CTRL, 16'h0002);
      repeat (3) @(posedge clock_i);
      `CHK({rwake, daddr}, 8'h00)
   endtask

   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   // Main sequence after four cycles of reset
   initial begin
      {arst_n_i, self_pwr, hw_halt, addr, wdata, we, re} = '0;
      tc = 0;
      err_count = 0;
      tests_run = 0;
      repeat (4) @(posedge clock_i);
      arst_n_i <= 1'b1;
      t_fresh();
      t_address();
      t_config();
      t_leave();
      close_out();
   end

   // The run needs under a thousand cycles; far beyond that is a hang
   initial begin
      repeat (20000) @(posedge clock_i);
      err_count++;
      close_out();
   end
endmodule // usrac_test
